//--- pkg/afr_map.svh
// Register offsets, field positions, reset values and word lengths
// Assumes inclusion by bare name from the package and design files.
`ifndef AFR_MAP_SVH
`define AFR_MAP_SVH

// ----------------------------------------
// Register addresses (six bits)
// ----------------------------------------
`define AFR_A_SETUP_ONE    6'h01
`define AFR_A_SETUP_TWO    6'h02
`define AFR_A_SETUP_THREE  6'h03
`define AFR_A_SOFT_RESET   6'h04
`define AFR_A_CYCLE_RESET  6'h05
`define AFR_A_SETUP_FOUR   6'h06
`define AFR_A_REVISION     6'h07
`define AFR_A_SETUP_FIVE   6'h08
`define AFR_A_SETUP_SIX    6'h09
`define AFR_A_SPARE_A      6'h0a
`define AFR_A_SPARE_B      6'h0b
`define AFR_A_SPARE_C      6'h0c
`define AFR_A_OFFSET_RED   6'h20
`define AFR_A_OFFSET_GREEN 6'h21
`define AFR_A_OFFSET_BLUE  6'h22
`define AFR_A_OFFSET_ALL   6'h23
`define AFR_A_GAIN_RED     6'h28
`define AFR_A_GAIN_GREEN   6'h29
`define AFR_A_GAIN_BLUE    6'h2a
`define AFR_A_GAIN_ALL     6'h2b

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AFR_RST_SETUP_ONE   8'h03
`define AFR_RST_SETUP_TWO   8'h20
`define AFR_RST_SETUP_THREE 8'h1f
`define AFR_RST_ZERO        8'h00
`define AFR_RST_OFFSET      8'h80
`define AFR_RST_GAIN        8'h00
// Arbitrary neutral revision value
`define AFR_REVISION_VAL    8'h5a

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define AFR_READ_BIT        4
`define AFR_ONE_DSAMP       1
`define AFR_ONE_MONO        2
`define AFR_ONE_MAXSPD      6
`define AFR_ONE_MASK        8'h7f
`define AFR_TWO_MASK        8'hef
`define AFR_FIVE_MASK       8'h1f
`define AFR_SIX_MASK        8'h0f
`define AFR_FOUR_LINESEQ    0
`define AFR_FOUR_ACYC       1
`define AFR_FOUR_FORCE      2
`define AFR_FIVE_DETECT     0
`define AFR_FIVE_POL        4

// ----------------------------------------
// Word lengths
// ----------------------------------------
`define AFR_ADDR_BITS       6
`define AFR_DATA_BITS       8
`define AFR_FRAME_BITS      14

`endif

//--- pkg/afr_pkg.sv
// Types shared by the front-end register bank
// Assumes afr_map.svh is on the include path.
`include "afr_map.svh"

package afr_pkg;

    // Colour selector codes
    typedef enum logic [1:0] {
        AFR_RED   = 2'h0,
        AFR_GREEN = 2'h1,
        AFR_BLUE  = 2'h2
    } afr_colour_t;

    // Decoded serial frame
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } afr_frame_t;

    // Mode selections seen by the sampling core
    typedef struct packed {
        logic [1:0] input_sel;
        logic [1:0] coef_sel;
        logic       green_blue_off;
        logic       double_sample_enable;
        logic       max_speed_select;
    } afr_route_t;

endpackage : afr_pkg

//--- logic/afr_sync.sv
// Three-stage synchroniser with agreement filter
// Assumes an asynchronous level input and one clock domain.
`timescale 1ns/1ns
`default_nettype none

module afr_sync (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic pin_in,
    output var  logic level_out
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ----------------------------------------
    // Capture chain
    // ----------------------------------------
    // Level moves only when stages two and three agree
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end

endmodule : afr_sync

`default_nettype wire

//--- logic/afr_regs.sv
// Control register bank of a three-channel scanner front end
// Assumes serial pins from a host, mclk far faster than the serial clock.
//
// Function
// - Colour pixel mode samples all three inputs in parallel, up to 4 MSPS.
// - Channel results are multiplexed into one converter stream, up to 12 MSPS.
// - Single-colour input chosen by setup_three bits 7:6.
// - Writes decode address bits a5 and a3:a0; the offset and gain all-colour addresses update three registers.
// - Timing relations stay the same with double sampling on or off.
// - Write is 6 address then 8 data bits, MSB first, rising clock, strobe.
// - Address bit a4 set reads the register out MSB first on falling edges.
// - Any write to soft reset address restores all registers to defaults.
// - Any write to cycle reset returns auto-cycle to red.
`timescale 1ns/1ns
`default_nettype none
`include "afr_map.svh"

module afr_regs (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              serial_clk,
    input  wire logic              serial_in,
    input  wire logic              serial_strobe,
    input  wire logic              cycle_pulse,
    output var  logic              serial_out,
    output var  logic [7:0]        setup_one_q,
    output var  logic [7:0]        setup_two_q,
    output var  logic [7:0]        setup_three_q,
    output var  logic [7:0]        setup_four_q,
    output var  logic [7:0]        setup_five_q,
    output var  logic [7:0]        setup_six_q,
    output var  logic [7:0]        offset_red_q,
    output var  logic [7:0]        offset_green_q,
    output var  logic [7:0]        offset_blue_q,
    output var  logic [7:0]        gain_red_q,
    output var  logic [7:0]        gain_green_q,
    output var  logic [7:0]        gain_blue_q,
    output var  afr_pkg::afr_route_t route_q
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sck_s;
    logic din_s;
    logic stb_s;
    logic acyc_s;

    afr_sync u_sck (.mclk(mclk), .arst_n(arst_n), .pin_in(serial_clk),    .level_out(sck_s));
    afr_sync u_din (.mclk(mclk), .arst_n(arst_n), .pin_in(serial_in),     .level_out(din_s));
    afr_sync u_stb (.mclk(mclk), .arst_n(arst_n), .pin_in(serial_strobe), .level_out(stb_s));
    afr_sync u_acy (.mclk(mclk), .arst_n(arst_n), .pin_in(cycle_pulse),   .level_out(acyc_s));

    logic sck_d_r;
    logic stb_d_r;
    logic acyc_d_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sck_d_r  <= 1'b0;
            stb_d_r  <= 1'b0;
            acyc_d_r <= 1'b0;
        end else begin
            sck_d_r  <= sck_s;
            stb_d_r  <= stb_s;
            acyc_d_r <= acyc_s;
        end
    end

    // Edge events
    wire sck_rise  = sck_s & ~sck_d_r;
    wire sck_fall  = ~sck_s & sck_d_r;
    wire stb_rise  = stb_s & ~stb_d_r;
    wire acyc_rise = acyc_s & ~acyc_d_r;

    // ----------------------------------------
    // Serial shifter
    // ----------------------------------------
    logic [13:0] shift_r;

    // Bits enter MSB first on rising serial clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= 14'h0000;
        end else if (sck_rise) begin
            shift_r <= {shift_r[12:0], din_s};
        end
    end

    afr_pkg::afr_frame_t frame;
    assign frame = shift_r;

    wire       is_read   = frame.addr[`AFR_READ_BIT];
    wire [5:0] reg_addr  = {frame.addr[5], 1'b0, frame.addr[3:0]};
    wire       wr_en     = stb_rise & ~is_read;
    wire       rd_en     = stb_rise & is_read;
    wire [7:0] wdata     = frame.data;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // One strobe per register; combined addresses fan out
    wire hit_one   = wr_en && reg_addr == `AFR_A_SETUP_ONE;
    wire hit_two   = wr_en && reg_addr == `AFR_A_SETUP_TWO;
    wire hit_three = wr_en && reg_addr == `AFR_A_SETUP_THREE;
    wire hit_four  = wr_en && reg_addr == `AFR_A_SETUP_FOUR;
    wire hit_five  = wr_en && reg_addr == `AFR_A_SETUP_FIVE;
    wire hit_six   = wr_en && reg_addr == `AFR_A_SETUP_SIX;
    wire hit_srst  = wr_en && reg_addr == `AFR_A_SOFT_RESET;
    wire hit_crst  = wr_en && reg_addr == `AFR_A_CYCLE_RESET;
    wire hit_oall  = wr_en && reg_addr == `AFR_A_OFFSET_ALL;
    wire hit_gall  = wr_en && reg_addr == `AFR_A_GAIN_ALL;
    wire hit_or    = wr_en && reg_addr == `AFR_A_OFFSET_RED   || hit_oall;
    wire hit_og    = wr_en && reg_addr == `AFR_A_OFFSET_GREEN || hit_oall;
    wire hit_ob    = wr_en && reg_addr == `AFR_A_OFFSET_BLUE  || hit_oall;
    wire hit_gr    = wr_en && reg_addr == `AFR_A_GAIN_RED     || hit_gall;
    wire hit_gg    = wr_en && reg_addr == `AFR_A_GAIN_GREEN   || hit_gall;
    wire hit_gb    = wr_en && reg_addr == `AFR_A_GAIN_BLUE    || hit_gall;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    // Soft reset writes defaults; revision has no storage
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            setup_one_q    <= `AFR_RST_SETUP_ONE;
            setup_two_q    <= `AFR_RST_SETUP_TWO;
            setup_three_q  <= `AFR_RST_SETUP_THREE;
            setup_four_q   <= `AFR_RST_ZERO;
            setup_five_q   <= `AFR_RST_ZERO;
            setup_six_q    <= `AFR_RST_ZERO;
            offset_red_q   <= `AFR_RST_OFFSET;
            offset_green_q <= `AFR_RST_OFFSET;
            offset_blue_q  <= `AFR_RST_OFFSET;
            gain_red_q     <= `AFR_RST_GAIN;
            gain_green_q   <= `AFR_RST_GAIN;
            gain_blue_q    <= `AFR_RST_GAIN;
        end else if (hit_srst) begin
            setup_one_q    <= `AFR_RST_SETUP_ONE;
            setup_two_q    <= `AFR_RST_SETUP_TWO;
            setup_three_q  <= `AFR_RST_SETUP_THREE;
            setup_four_q   <= `AFR_RST_ZERO;
            setup_five_q   <= `AFR_RST_ZERO;
            setup_six_q    <= `AFR_RST_ZERO;
            offset_red_q   <= `AFR_RST_OFFSET;
            offset_green_q <= `AFR_RST_OFFSET;
            offset_blue_q  <= `AFR_RST_OFFSET;
            gain_red_q     <= `AFR_RST_GAIN;
            gain_green_q   <= `AFR_RST_GAIN;
            gain_blue_q    <= `AFR_RST_GAIN;
        end else begin
            if (hit_one)   setup_one_q    <= wdata & `AFR_ONE_MASK;
            if (hit_two)   setup_two_q    <= wdata & `AFR_TWO_MASK;
            if (hit_three) setup_three_q  <= wdata;
            if (hit_four)  setup_four_q   <= wdata;
            if (hit_five)  setup_five_q   <= wdata & `AFR_FIVE_MASK;
            if (hit_six)   setup_six_q    <= wdata & `AFR_SIX_MASK;
            if (hit_or)    offset_red_q   <= wdata;
            if (hit_og)    offset_green_q <= wdata;
            if (hit_ob)    offset_blue_q  <= wdata;
            if (hit_gr)    gain_red_q     <= wdata;
            if (hit_gg)    gain_green_q   <= wdata;
            if (hit_gb)    gain_blue_q    <= wdata;
        end
    end

    // ----------------------------------------
    // Read-back mux
    // ----------------------------------------
    logic [7:0] rd_val;

    // Unmapped, spare and write-only addresses read zero
    always_comb begin
        unique case (reg_addr)
            `AFR_A_SETUP_ONE:    rd_val = setup_one_q;
            `AFR_A_SETUP_TWO:    rd_val = setup_two_q;
            `AFR_A_SETUP_THREE:  rd_val = setup_three_q;
            `AFR_A_SETUP_FOUR:   rd_val = setup_four_q;
            `AFR_A_REVISION:     rd_val = `AFR_REVISION_VAL;
            `AFR_A_SETUP_FIVE:   rd_val = setup_five_q;
            `AFR_A_SETUP_SIX:    rd_val = setup_six_q;
            `AFR_A_OFFSET_RED:   rd_val = offset_red_q;
            `AFR_A_OFFSET_GREEN: rd_val = offset_green_q;
            `AFR_A_OFFSET_BLUE:  rd_val = offset_blue_q;
            `AFR_A_GAIN_RED:     rd_val = gain_red_q;
            `AFR_A_GAIN_GREEN:   rd_val = gain_green_q;
            `AFR_A_GAIN_BLUE:    rd_val = gain_blue_q;
            default:             rd_val = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Read-back shifter
    // ----------------------------------------
    logic [7:0] out_sh_r;
    logic [3:0] out_cnt_r;

    // Load on strobe, present MSB, advance on falling serial clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_sh_r   <= 8'h00;
            out_cnt_r  <= 4'h0;
            serial_out <= 1'b0;
        end else if (rd_en) begin
            out_sh_r   <= {rd_val[6:0], 1'b0};
            out_cnt_r  <= 4'h7;
            serial_out <= rd_val[7];
        end else if (sck_fall && out_cnt_r != 4'h0) begin
            out_sh_r   <= {out_sh_r[6:0], 1'b0};
            out_cnt_r  <= out_cnt_r - 4'h1;
            serial_out <= out_sh_r[7];
        end
    end

    // ----------------------------------------
    // Auto-cycle colour sequencer
    // ----------------------------------------
    afr_pkg::afr_colour_t cyc_r;
    afr_pkg::afr_colour_t cyc_nxt;

    always_comb begin
        unique case (cyc_r)
            afr_pkg::AFR_RED:   cyc_nxt = afr_pkg::AFR_GREEN;
            afr_pkg::AFR_GREEN: cyc_nxt = afr_pkg::AFR_BLUE;
            default:            cyc_nxt = afr_pkg::AFR_RED;
        endcase
    end

    wire acyc_on = setup_four_q[`AFR_FOUR_ACYC];

    // Cycle-reset and soft reset win over a pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_r <= afr_pkg::AFR_RED;
        end else if (hit_crst || hit_srst) begin
            cyc_r <= afr_pkg::AFR_RED;
        end else if (acyc_rise && acyc_on) begin
            cyc_r <= cyc_nxt;
        end
    end

    // ----------------------------------------
    // Route selection
    // ----------------------------------------
    wire       line_seq  = setup_four_q[`AFR_FOUR_LINESEQ];
    wire       force_en  = setup_four_q[`AFR_FOUR_FORCE];
    wire [1:0] colour_pick = setup_four_q[5:4];
    wire [1:0] force_pick  = setup_four_q[7:6];
    wire [1:0] mono_pick   = setup_three_q[7:6];
    wire [1:0] coef_line   = acyc_on ? cyc_r : colour_pick;
    wire [1:0] in_line     = force_en ? force_pick : coef_line;
    wire       mono      = setup_one_q[`AFR_ONE_MONO];
    wire       maxspd    = setup_one_q[`AFR_ONE_MAXSPD];

    afr_pkg::afr_route_t route_nxt;

    // Line mode follows mux modes; mono uses channel field
    always_comb begin
        route_nxt.input_sel            = line_seq ? in_line : mono_pick;
        route_nxt.coef_sel             = line_seq ? coef_line : mono_pick;
        route_nxt.green_blue_off       = line_seq;
        route_nxt.double_sample_enable = setup_one_q[`AFR_ONE_DSAMP] & ~maxspd;
        route_nxt.max_speed_select     = maxspd;
        if (!line_seq && !mono) begin
            route_nxt.input_sel = afr_pkg::AFR_RED;
            route_nxt.coef_sel  = afr_pkg::AFR_RED;
        end
    end

    // Route is pure configuration; no timing path depends on it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            route_q <= '0;
        end else begin
            route_q <= route_nxt;
        end
    end

endmodule : afr_regs

`default_nettype wire

//--- dv/afr_regs_properties.sv
// Concurrent checks on the front-end register bank ports
// Assumes one mclk domain; bound onto every afr_regs instance.
`timescale 1ns/1ns
`default_nettype none

module afr_regs_properties (
    input wire logic                mclk,
    input wire logic                arst_n,
    input wire logic                serial_clk,
    input wire logic                serial_strobe,
    input wire logic                serial_out,
    input wire logic [7:0]          setup_one_q,
    input wire logic [7:0]          setup_two_q,
    input wire logic [7:0]          setup_three_q,
    input wire logic [7:0]          setup_four_q,
    input wire logic [7:0]          setup_five_q,
    input wire logic [7:0]          setup_six_q,
    input wire logic [7:0]          offset_red_q,
    input wire logic [7:0]          gain_red_q,
    input wire afr_pkg::afr_route_t route_q
);
    // ----------------------------------------
    // Event ages
    // ----------------------------------------
    localparam int LO = 3;
    localparam int HI = 9;
    logic [7:0] strb_age_r;
    logic [7:0] fall_age_r;
    logic       strb_r;
    logic       sclk_r;
    wire  [47:0] bank = {setup_one_q, setup_two_q, setup_three_q, setup_four_q, offset_red_q, gain_red_q};
    wire  strb_rise = serial_strobe && !strb_r;
    wire  sclk_fall = !serial_clk && sclk_r;

    // Cycles since last strobe rise and serial clock fall
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            strb_r     <= 1'b0;
            sclk_r     <= 1'b0;
            strb_age_r <= 8'hff;
            fall_age_r <= 8'hff;
        end else begin
            strb_r     <= serial_strobe;
            sclk_r     <= serial_clk;
            strb_age_r <= strb_rise ? 8'h00 : strb_age_r + {7'h00, strb_age_r != 8'hff};
            fall_age_r <= sclk_fall ? 8'h00 : fall_age_r + {7'h00, fall_age_r != 8'hff};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_fixed_zero;
        {setup_one_q[7], setup_two_q[4], setup_five_q[7:5], setup_six_q[7:4]} == 9'h000;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero) else $error("fixed zero bit set");
    property p_bank_quiet;
        !$stable(bank) |-> strb_age_r inside {[LO:HI]};
    endproperty
    a_bank_quiet: assert property (p_bank_quiet) else $error("register moved without strobe");
    property p_out_quiet;
        !$stable(serial_out) |-> (fall_age_r inside {[LO:HI]}) || (strb_age_r inside {[LO:HI]});
    endproperty
    a_out_quiet: assert property (p_out_quiet) else $error("read data moved off a falling edge");
    property p_colour_red;
        (!setup_one_q[2] && !setup_four_q[0]) [*2] |-> route_q.input_sel == afr_pkg::AFR_RED;
    endproperty
    a_colour_red: assert property (p_colour_red) else $error("colour pixel mode not on red");
    property p_mono_sel;
        (setup_one_q[2] && setup_four_q[2:0] == 3'h0 && $stable(setup_three_q)) [*2]
            |-> route_q.input_sel == setup_three_q[7:6];
    endproperty
    a_mono_sel: assert property (p_mono_sel) else $error("mono input select wrong");
    property p_max_speed;
        setup_one_q[6] [*2] |-> route_q.max_speed_select && !route_q.double_sample_enable;
    endproperty
    a_max_speed: assert property (p_max_speed) else $error("double sampling in max speed");
    property p_cds_follow;
        (!setup_one_q[6] && $stable(setup_one_q[1])) [*2] |-> route_q.double_sample_enable == setup_one_q[1];
    endproperty
    a_cds_follow: assert property (p_cds_follow) else $error("double sampling select wrong");
    property p_line_internal;
        (setup_four_q[2:0] == 3'h1 && $stable(setup_four_q[5:4])) [*2] |-> route_q.green_blue_off
            && route_q.input_sel == setup_four_q[5:4] && route_q.coef_sel == setup_four_q[5:4];
    endproperty
    a_line_internal: assert property (p_line_internal) else $error("line mode select wrong");

    // Main scenarios reached
    c_strobe: cover property (strb_rise);
    c_max_speed: cover property (route_q.max_speed_select);
    c_green: cover property (setup_four_q[1] && route_q.input_sel == afr_pkg::AFR_GREEN);
endmodule : afr_regs_properties

bind afr_regs afr_regs_properties u_props (
    .mclk(mclk), .arst_n(arst_n), .serial_clk(serial_clk), .serial_strobe(serial_strobe),
    .serial_out(serial_out), .setup_one_q(setup_one_q), .setup_two_q(setup_two_q),
    .setup_three_q(setup_three_q), .setup_four_q(setup_four_q), .setup_five_q(setup_five_q),
    .setup_six_q(setup_six_q), .offset_red_q(offset_red_q), .gain_red_q(gain_red_q), .route_q(route_q)
);
`default_nettype wire

//--- dv/afr_host.sv
// Host controller model on the three-wire serial port
// Assumes mclk from the bench; serial clock idles low between frames.
`timescale 1ns/1ns
`default_nettype none

module afr_host (
    input  wire logic mclk,
    input  wire logic serial_out,
    output var  logic serial_clk,
    output var  logic serial_in,
    output var  logic serial_strobe
);
    // Half period of the 64 ns serial clock, in mclk cycles
    localparam int HALF = 8;

    // Idle levels
    initial begin
        serial_clk    = 1'b0;
        serial_in     = 1'b0;
        serial_strobe = 1'b0;
    end

    // Wait on falling mclk edges
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask : wt

    // Address then data, MSB first, then a strobe with the clock low
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        logic [13:0] w;
        w = {a, d};
        for (int i = 13; i >= 0; i--) begin
            serial_in = w[i];
            wt(HALF);
            serial_clk = 1'b1;
            wt(HALF);
            serial_clk = 1'b0;
        end
        serial_in = ~serial_in;
        wt(HALF);
        serial_strobe = 1'b1;
        wt(HALF);
        serial_strobe = 1'b0;
        wt(2 * HALF);
    endtask : write_reg

    // Read request with a4 set, then one bit per falling clock edge
    task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
        write_reg(a | 6'h10, 8'h00);
        for (int i = 7; i >= 0; i--) begin
            d[i] = serial_out;
            if (i > 0) begin
                serial_clk = 1'b1;
                wt(HALF);
                serial_clk = 1'b0;
                wt(2 * HALF);
            end
        end
    endtask : read_reg
endmodule : afr_host
`default_nettype wire

//--- dv/afr_regs_bench.sv
// Self-checking bench for the front-end register bank
// Assumes the host model drives the serial port on falling mclk edges.
`timescale 1ns/1ns
`default_nettype none
`include "afr_map.svh"

module afr_regs_bench;
    logic mclk        = 1'b0;
    logic arst_n      = 1'b0;
    logic cycle_pulse = 1'b0;
    logic serial_clk, serial_in, serial_strobe, serial_out;
    logic [7:0] s1, s2, s3, s4, s5, s6, o_r, o_g, o_b, g_r, g_g, g_b;
    afr_pkg::afr_route_t rt;
    int num_errors = 0;
    int n_tests    = 0;
    int cyc        = 0;
    localparam int LIMIT = 40000;
    // Readable registers, reset values and writable bits
    logic [5:0] ra [13] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h07, 6'h08, 6'h09,
                            6'h20, 6'h21, 6'h22, 6'h28, 6'h29, 6'h2a};
    logic [7:0] rv [13] = '{8'h03, 8'h20, 8'h1f, 8'h00, `AFR_REVISION_VAL, 8'h00, 8'h00,
                            8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [7:0] rm [13] = '{8'h7f, 8'hef, 8'hff, 8'hff, 8'h00, 8'h1f, 8'h0f,
                            8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    afr_host host (.mclk(mclk), .serial_out(serial_out), .serial_clk(serial_clk),
                   .serial_in(serial_in), .serial_strobe(serial_strobe));
    afr_regs uut (.mclk(mclk), .arst_n(arst_n), .serial_clk(serial_clk), .serial_in(serial_in),
                  .serial_strobe(serial_strobe), .cycle_pulse(cycle_pulse), .serial_out(serial_out),
                  .setup_one_q(s1), .setup_two_q(s2), .setup_three_q(s3), .setup_four_q(s4),
                  .setup_five_q(s5), .setup_six_q(s6), .offset_red_q(o_r), .offset_green_q(o_g),
                  .offset_blue_q(o_b), .gain_red_q(g_r), .gain_green_q(g_g), .gain_blue_q(g_b), .route_q(rt));

    // 250 MHz clock and hang guard
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            finish_test();
        end
    end

    // Compare and count
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read back one register and compare
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        chk(d, exp);
    endtask : rd

    // One pulse on the auto-cycle pin
    task automatic pulse();
        cycle_pulse = 1'b1;
        host.wt(8);
        cycle_pulse = 1'b0;
        host.wt(16);
    endtask : pulse

    // Verdict
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Test sequence
    initial begin
        repeat (8) @(negedge mclk);
        arst_n = 1'b1;
        host.wt(8);
        for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
        for (int i = 0; i < 13; i++) host.write_reg(ra[i], 8'hc0 | 8'(ra[i]) | {8{i == 4}});
        for (int i = 0; i < 13; i++) rd(ra[i], (i == 4) ? rv[i] : ((8'hc0 | 8'(ra[i])) & rm[i]));
        host.write_reg(`AFR_A_SPARE_A, 8'hff);
        rd(`AFR_A_SPARE_A, 8'h00);
        rd(`AFR_A_OFFSET_ALL, 8'h00);
        rd(6'h3f, 8'h00);
        $display("test map done");
        host.write_reg(`AFR_A_OFFSET_ALL, 8'h3c);
        chk({o_r, o_g, o_b}, 24'h3c3c3c);
        host.write_reg(`AFR_A_GAIN_ALL, 8'hc3);
        chk({g_r, g_g, g_b}, 24'hc3c3c3);
        host.write_reg(`AFR_A_SOFT_RESET, 8'ha5);
        chk({s1, s2, s3, s4, s5, s6, o_r, o_g, o_b, g_r, g_g, g_b}, {48'h03201f000000, 24'h808080, 24'h0});
        $display("test group and reset done");
        chk({rt.input_sel, rt.double_sample_enable}, {afr_pkg::AFR_RED, 1'b1});
        host.write_reg(`AFR_A_SETUP_ONE, 8'h45);
        chk({rt.max_speed_select, rt.double_sample_enable}, 2'h2);
        host.write_reg(`AFR_A_SETUP_ONE, 8'h07);
        host.write_reg(`AFR_A_SETUP_THREE, 8'h8f);
        chk({rt.input_sel, rt.double_sample_enable}, {afr_pkg::AFR_BLUE, 1'b1});
        host.write_reg(`AFR_A_SETUP_FOUR, 8'h21);
        chk({rt.input_sel, rt.coef_sel, rt.green_blue_off}, {afr_pkg::AFR_BLUE, afr_pkg::AFR_BLUE, 1'b1});
        host.write_reg(`AFR_A_SETUP_FOUR, 8'h65);
        chk({rt.input_sel, rt.coef_sel}, {afr_pkg::AFR_GREEN, afr_pkg::AFR_BLUE});
        host.write_reg(`AFR_A_SETUP_FOUR, 8'h03);
        pulse();
        chk({rt.input_sel, rt.coef_sel}, {afr_pkg::AFR_GREEN, afr_pkg::AFR_GREEN});
        pulse();
        chk(rt.input_sel, afr_pkg::AFR_BLUE);
        host.write_reg(`AFR_A_CYCLE_RESET, 8'h5a);
        chk({rt.input_sel, rt.coef_sel}, {afr_pkg::AFR_RED, afr_pkg::AFR_RED});
        $display("test modes done");
        finish_test();
    end
endmodule : afr_regs_bench
`default_nettype wire
